// >>> rtl/cpsq_core.v
`timescale 1ns/1ns
`default_nettype none
`include "cpsq_map.vh"
module cpsq_core (
    // Clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // Sequencer command, one cycle per instruction
    input  wire        step_valid,
    input  wire [3:0]  step_op,
    input  wire [2:0]  instr_bytes,
    input  wire        cond_taken,
    input  wire [16:0] abs_target,
    input  wire [11:0] rel12,
    input  wire [7:0]  rel8,
    input  wire [3:0]  int_source,
    input  wire [15:0] stack_ptr,
    // Return words read from RAM at SP and SP-1
    input  wire [8:0]  ret_hi_word,
    input  wire [8:0]  ret_lo_word,
    // Program address out
    output wire [16:0] pc_addr,
    output wire        bank_select_flag,
    output wire [17:0] rom_addr,
    output wire        opt_area_hit,
    // Stack save writes
    output reg         stk_we,
    output reg  [15:0] stk_addr,
    output reg  [8:0]  stk_wdata,
    output wire        stk_second,
    output wire [15:0] stack_ptr_next,
    // Data space access
    input  wire        dm_we,
    input  wire [15:0] dm_addr,
    input  wire [7:0]  dm_wdata,
    input  wire        flag_ram8_in,
    output wire [7:0]  dm_rdata,
    output wire        dm_is_ram,
    output wire        dm_ram_we,
    output wire [8:0]  dm_ram_wdata,
    // Core result loads of working registers
    input  wire        acc_core_we,
    input  wire [7:0]  acc_core_wdata,
    input  wire        muldiv_we,
    input  wire [23:0] muldiv_result,
    // Table lookup
    input  wire        table_lookup_instr,
    input  wire        lookup_bank,
    input  wire [8:0]  ireg_hi,
    input  wire [7:0]  ireg_lo,
    output wire [17:0] lookup_addr,
    // Register-plus-offset addressing
    input  wire [15:0] ireg_value,
    output wire [15:0] offset_addr,
    input  wire [5:0]  ireg_index,
    output wire [15:0] ireg_byte_addr,
    // External memory access
    input  wire        ext_load_instr,
    input  wire        ext_store_instr,
    input  wire [15:0] ext_low_addr,
    output wire [23:0] ext_addr,
    // Working register views
    output wire [15:0] wide_operand,
    output wire [7:0]  accumulator_reg,
    output wire [7:0]  second_work_reg,
    output wire [7:0]  third_work_reg
);
    // ==========================================================
    // Program counter state
    reg  [16:0] pc_q;
    reg  [16:0] pc_d;
    reg         bank_q;
    reg         bank_d;
    reg         save_hi_q;
    reg  [8:0]  save_hi_data_q;
    reg  [15:0] save_sp_q;
    reg  [16:0] add_base;
    reg  [2:0]  add_step;
    reg  [16:0] add_off;
    wire [16:0] add_sum;
    wire [16:0] vec_addr;

    // Interrupt vectors sit eight bytes apart from the first one,
    // leaving room for a short jump at each entry point.
    // The source index comes from the interrupt controller already
    // prioritised; this block only turns it into an address.
    // A source number past the last slot would otherwise land in
    // program code, so it is clamped rather than left to wrap.
    // Vector = base + 8 * source; sources above the last clamp to it
    assign vec_addr = `CPSQ_VEC_BASE
                    + {10'h000, ((int_source < `CPSQ_VEC_COUNT) ? int_source
                                 : (`CPSQ_VEC_COUNT - 4'h1)), 3'b000};

    // One shared adder serves sequential advance, relative branches,
    // relative calls and conditional branches. Sharing it keeps the
    // next-address path to a single carry chain; the cost is that
    // the operand mux sits in front of it on the critical path.
    // The rel12 and rel8 offsets are sign-extended to the full 17 bits so that a
    // backward branch wraps inside the bank and never touches it.
    // Adder operand select
    always @* begin
        add_base = pc_q;
        add_step = instr_bytes;
        add_off  = 17'h00000;
        case (step_op)
            `CPSQ_OP_BR, `CPSQ_OP_RELATIVE_CALL_INSTR: begin
                add_step = 3'h2;
                add_off  = {{5{rel12[11]}}, rel12};
            end
            `CPSQ_OP_ACC_RELATIVE_CALL_INSTR: begin
                add_step = 3'h1;
                add_off  = {9'h000, accumulator_reg};
            end
            `CPSQ_OP_BCOND: begin
                add_off  = cond_taken ? {{9{rel8[7]}}, rel8} : 17'h00000;
            end
            default: begin
                add_off  = 17'h00000;
            end
        endcase
    end

    cpsq_pc_adder u_adder (
        .base   (add_base),
        .step   (add_step),
        .offset (add_off),
        .sum    (add_sum)
    );

    // The bank flag is never touched by jumps, calls or branches:
    // the only way into bank 1 is to push a prepared address and
    // return through it; an interrupt clears the flag to bank 0.
    // An idle cycle (no step) holds both address and bank.
    // Next program address; bank moves only on a return or an interrupt
    always @* begin
        pc_d   = pc_q;
        bank_d = bank_q;
        if (step_valid) begin
            case (step_op)
                `CPSQ_OP_JUMP, `CPSQ_OP_CALL: begin
                    pc_d = abs_target;
                end
                `CPSQ_OP_RET: begin
                    pc_d   = {ret_hi_word, ret_lo_word[7:0]};
                    bank_d = ret_lo_word[8];
                end
                `CPSQ_OP_INT: begin
                    pc_d   = vec_addr;
                    bank_d = 1'b0;
                end
                `CPSQ_OP_SEQ, `CPSQ_OP_BR, `CPSQ_OP_RELATIVE_CALL_INSTR,
                `CPSQ_OP_ACC_RELATIVE_CALL_INSTR, `CPSQ_OP_BCOND: begin
                    pc_d = add_sum;
                end
                default: begin
                    pc_d = pc_q;
                end
            endcase
        end
    end

    // Reset start at address zero in bank 0
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pc_q   <= `CPSQ_PC_RESET;
            bank_q <= 1'b0;
        end else begin
            pc_q   <= pc_d;
            bank_q <= bank_d;
        end
    end

    assign pc_addr          = pc_q;
    assign bank_select_flag = bank_q;
    assign rom_addr         = {bank_q, pc_q};
    // Option area flagged so the fetch path can refuse it
    assign opt_area_hit     = !bank_q && (pc_q >= `CPSQ_OPT_LO)
                              && (pc_q <= `CPSQ_OPT_HI);

    // ==========================================================
    // Return address save: two RAM writes on consecutive cycles
    wire is_save = step_valid && ((step_op == `CPSQ_OP_CALL)
                   || (step_op == `CPSQ_OP_RELATIVE_CALL_INSTR) || (step_op == `CPSQ_OP_ACC_RELATIVE_CALL_INSTR)
                   || (step_op == `CPSQ_OP_INT));
    wire [16:0] ret_pc = (step_op == `CPSQ_OP_INT) ? pc_q : add_sum;
    wire [16:0] seq_pc = pc_q + {14'h0000, instr_bytes};
    wire [16:0] link_pc = (step_op == `CPSQ_OP_RELATIVE_CALL_INSTR || step_op == `CPSQ_OP_ACC_RELATIVE_CALL_INSTR)
                          ? seq_pc : ((step_op == `CPSQ_OP_INT) ? ret_pc : seq_pc);

    // The RAM has a single write port, so a save takes two cycles:
    // bank plus low byte in the cycle of the call, high nine bits
    // in the next one. The stack pointer is held outside and
    // advanced by two through stack_ptr_next.
    // Limitation: a new save in the cycle of a pending second
    // write loses its first write; the sequencer must space saves apart.
    // Second write held one cycle; the low half goes first
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            save_hi_q      <= 1'b0;
            save_hi_data_q <= 9'h000;
            save_sp_q      <= 16'h0000;
        end else begin
            save_hi_q      <= is_save;
            save_hi_data_q <= link_pc[16:8];
            save_sp_q      <= stack_ptr + 16'h0002;
        end
    end

    // Stack write port
    always @* begin
        stk_we    = 1'b0;
        stk_addr  = 16'h0000;
        stk_wdata = 9'h000;
        if (save_hi_q) begin
            stk_we    = 1'b1;
            stk_addr  = save_sp_q;
            stk_wdata = save_hi_data_q;
        end else if (is_save) begin
            stk_we    = 1'b1;
            stk_addr  = stack_ptr + 16'h0001;
            stk_wdata = {bank_q, link_pc[7:0]};
        end
    end
    assign stk_second     = save_hi_q;
    // Callers must hold off a new save until the second write is out
    assign stack_ptr_next = is_save ? stack_ptr + 16'h0002 : stack_ptr;

    // ==========================================================
    // Data space decode and working registers
    // The three working registers answer at their fixed SFR
    // addresses; every other SFR lives in another block and its
    // read data is merged elsewhere, so this mux returns zero.
    // Core loads take priority over a store from the data bus,
    // since an instruction result must not be lost to a move.
    wire       sel_acc    = (dm_addr == `CPSQ_ACC_ADDR);
    wire       sel_second = (dm_addr == `CPSQ_SECOND_ADDR);
    wire       sel_third  = (dm_addr == `CPSQ_THIRD_ADDR);
    assign dm_is_ram    = (dm_addr <= `CPSQ_RAM_TOP);
    assign dm_ram_we    = dm_we && dm_is_ram;
    // Ninth bit rides on the flag word bit
    assign dm_ram_wdata = {flag_ram8_in, dm_wdata};

    cpsq_work_reg u_acc (
        .clock      (clock),
        .rst_n      (rst_n),
        .bus_we     (dm_we && sel_acc),
        .bus_wdata  (dm_wdata),
        .core_we    (acc_core_we || muldiv_we),
        .core_wdata (muldiv_we ? muldiv_result[7:0] : acc_core_wdata),
        .value      (accumulator_reg)
    );
    cpsq_work_reg u_second (
        .clock      (clock),
        .rst_n      (rst_n),
        .bus_we     (dm_we && sel_second),
        .bus_wdata  (dm_wdata),
        .core_we    (muldiv_we),
        .core_wdata (muldiv_result[15:8]),
        .value      (second_work_reg)
    );
    cpsq_work_reg u_third (
        .clock      (clock),
        .rst_n      (rst_n),
        .bus_we     (dm_we && sel_third),
        .bus_wdata  (dm_wdata),
        .core_we    (muldiv_we),
        .core_wdata (muldiv_result[23:16]),
        .value      (third_work_reg)
    );

    // Read mux: other SFRs live elsewhere and read as zero here
    assign dm_rdata = sel_acc ? accumulator_reg :
                      sel_second ? second_work_reg :
                      sel_third ? third_work_reg : 8'h00;

    // ==========================================================
    // Address formers
    // All of these are pure combinational views of the registers;
    // the consuming units latch what they need in their own stage.
    // The signed offset of the third register reaches -128..+127
    // around the indirect register and wraps in 64K data space.
    assign wide_operand   = {second_work_reg, accumulator_reg};
    assign ext_addr       = (ext_load_instr || ext_store_instr)
                            ? {second_work_reg, ext_low_addr} : 24'h000000;
    assign offset_addr    = ireg_value + {{8{third_work_reg[7]}}, third_work_reg};
    assign ireg_byte_addr = {9'h000, ireg_index, 1'b0};
    // Bank taken from the lookup bank flag in the flag word
    assign lookup_addr    = table_lookup_instr
                            ? {lookup_bank, ireg_hi, ireg_lo} : 18'h00000;
endmodule
`default_nettype wire

// >>> rtl/cpsq_map.vh
`ifndef CPSQ_MAP_VH
`define CPSQ_MAP_VH
// ==========================================================
// Program space
`define CPSQ_PC_W         17
`define CPSQ_PC_RESET     17'h00000
`define CPSQ_VEC_BASE     17'h00003
`define CPSQ_VEC_STEP     17'h00008
`define CPSQ_VEC_COUNT    4'hA
`define CPSQ_OPT_LO       17'h0FF00
`define CPSQ_OPT_HI       17'h0FFFF
// ==========================================================
// Data space
`define CPSQ_RAM_TOP      16'hFDFF
`define CPSQ_SFR_BASE     16'hFE00
`define CPSQ_ACC_ADDR     16'hFE00
`define CPSQ_SECOND_ADDR  16'hFE01
`define CPSQ_THIRD_ADDR   16'hFE02
`define CPSQ_IREG_TOP     16'h007F
`define CPSQ_REG_RESET    8'h00
`define CPSQ_FLAG_RAM8    1
// ==========================================================
// Next-PC operations
`define CPSQ_OP_SEQ       4'h0
`define CPSQ_OP_JUMP      4'h1
`define CPSQ_OP_CALL      4'h2
`define CPSQ_OP_BR        4'h3
`define CPSQ_OP_RELATIVE_CALL_INSTR     4'h4
`define CPSQ_OP_ACC_RELATIVE_CALL_INSTR    4'h5
`define CPSQ_OP_BCOND     4'h6
`define CPSQ_OP_RET       4'h7
`define CPSQ_OP_INT       4'h8
`endif

// >>> rtl/cpsq_pc_adder.v
`timescale 1ns/1ns
`default_nettype none
`include "cpsq_map.vh"
// ==========================================================
// Program address adder: base + step + offset, sign- or zero-extended to 17 bits by the caller
module cpsq_pc_adder (
    // Operands
    input  wire [16:0] base,
    input  wire [2:0]  step,
    input  wire [16:0] offset,
    // Result
    output wire [16:0] sum
);
    // Wraps inside the current 128K bank
    assign sum = base + {14'h0000, step} + offset;
endmodule
`default_nettype wire

// >>> rtl/cpsq_work_reg.v
`timescale 1ns/1ns
`default_nettype none
`include "cpsq_map.vh"
// ==========================================================
// One 8-bit working register, bus write or core load
module cpsq_work_reg (
    // Clock and reset
    input  wire       clock,
    input  wire       rst_n,
    // Write sources
    input  wire       bus_we,
    input  wire [7:0] bus_wdata,
    input  wire       core_we,
    input  wire [7:0] core_wdata,
    // Value
    output wire [7:0] value
);
    reg [7:0] value_q;
    // Core result wins over a bus store in the same cycle
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= `CPSQ_REG_RESET;
        end else if (core_we) begin
            value_q <= core_wdata;
        end else if (bus_we) begin
            value_q <= bus_wdata;
        end
    end
    assign value = value_q;
endmodule
`default_nettype wire

// >>> tb/cpsq_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpsq_map.vh"
// ==========================================================
// Sequencer and working register checks
module cpsq_properties (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // Step command
    input wire logic        step_valid,
    input wire logic [3:0]  step_op,
    input wire logic [2:0]  instr_bytes,
    input wire logic [16:0] abs_target,
    input wire logic [11:0] rel12,
    input wire logic [3:0]  int_source,
    input wire logic [15:0] stack_ptr,
    input wire logic [8:0]  ret_hi_word,
    input wire logic [8:0]  ret_lo_word,
    // Observed outputs
    input wire logic [16:0] pc_addr,
    input wire logic        bank_select_flag,
    input wire logic        stk_we,
    input wire logic [15:0] stk_addr,
    input wire logic [8:0]  stk_wdata,
    input wire logic [15:0] wide_operand,
    input wire logic [7:0]  accumulator_reg,
    input wire logic [7:0]  second_work_reg,
    input wire logic [7:0]  third_work_reg
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Expected targets; out-of-range sources clamp to the last vector
    wire [3:0]  op     = step_valid ? step_op : 4'hF;
    wire [16:0] link   = pc_addr + {14'h0, instr_bytes};
    wire [8:0]  link_hi = link[16:8];
    wire [16:0] br_tgt = pc_addr + 17'h2 + {{5{rel12[11]}}, rel12};
    wire [3:0]  src    = (int_source > 4'h9) ? 4'h9 : int_source;
    wire [16:0] vec    = 17'h3 + {10'h0, src, 3'h0};
    wire [17:0] popped = {ret_lo_word[8], ret_hi_word, ret_lo_word[7:0]};
    // Two-step stack save of a call
    sequence save_low_s;
        stk_we && stk_addr == stack_ptr + 16'h1 && stk_wdata == {bank_select_flag, link[7:0]};
    endsequence
    sequence save_high_s;
        stk_we && stk_addr == $past(stack_ptr) + 16'h2 && stk_wdata == $past(link_hi);
    endsequence
    // ==========================================================
    // Properties
    reset_pc_a: assert property ($rose(rst_n) |-> pc_addr == 17'h0 && !bank_select_flag)
        else $error("pc not cleared by reset");
    reset_regs_a: assert property ($rose(rst_n) |-> {accumulator_reg, second_work_reg, third_work_reg} == 24'h0)
        else $error("working registers not cleared");
    seq_step_a: assert property (op == `CPSQ_OP_SEQ |=> pc_addr == $past(link) && $stable(bank_select_flag))
        else $error("sequential advance wrong");
    abs_load_a: assert property (op inside {`CPSQ_OP_JUMP, `CPSQ_OP_CALL} |=> pc_addr == $past(abs_target) && $stable(bank_select_flag))
        else $error("absolute target wrong");
    rel_branch_a: assert property (op == `CPSQ_OP_BR |=> pc_addr == $past(br_tgt))
        else $error("relative branch wrong");
    int_vector_a: assert property (op == `CPSQ_OP_INT |=> pc_addr == $past(vec) && !bank_select_flag)
        else $error("interrupt vector wrong");
    ret_pop_a: assert property (op == `CPSQ_OP_RET |=> {bank_select_flag, pc_addr} == $past(popped))
        else $error("return address wrong");
    call_save_a: assert property (op inside {`CPSQ_OP_CALL, `CPSQ_OP_RELATIVE_CALL_INSTR, `CPSQ_OP_ACC_RELATIVE_CALL_INSTR} |-> save_low_s ##1 save_high_s)
        else $error("call save writes wrong");
    wide_pair_a: assert property (wide_operand == {second_work_reg, accumulator_reg})
        else $error("wide operand wrong");
endmodule
`default_nettype wire

// >>> tb/cpsq_ram_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Nine-bit stack RAM; reads are live, so a pop sees fresh data
module cpsq_ram_model (
    // Clock
    input wire logic        clock,
    // Save writes
    input wire logic        stk_we,
    input wire logic [15:0] stk_addr,
    input wire logic [8:0]  stk_wdata,
    // Pop reads
    input wire logic [15:0] stack_ptr,
    output logic     [8:0]  ret_hi_word,
    output logic     [8:0]  ret_lo_word
);
    logic [8:0] mem [0:65535];
    // Store all nine bits
    always @(posedge clock) begin
        if (stk_we) mem[stk_addr] <= stk_wdata;
    end
    assign ret_hi_word = mem[stack_ptr];
    assign ret_lo_word = mem[stack_ptr - 16'h1];
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpsq_map.vh"
module tb_top;
    logic clock, rst_n, step_valid, cond_taken, dm_we, flag_ram8_in, acc_core_we, muldiv_we;
    logic table_lookup_instr, lookup_bank, ext_load_instr, ext_store_instr, bank_select_flag;
    logic opt_area_hit, stk_we, dm_is_ram, stk_second, dm_ram_we;
    logic [8:0] dm_ram_wdata;
    logic [2:0] instr_bytes;
    logic [3:0] step_op, int_source;
    logic [5:0] ireg_index;
    logic [7:0] rel8, dm_wdata, acc_core_wdata, ireg_lo, dm_rdata;
    logic [7:0] accumulator_reg, second_work_reg, third_work_reg;
    logic [8:0] ireg_hi, ret_hi_word, ret_lo_word, stk_wdata;
    logic [11:0] rel12;
    logic [15:0] stack_ptr, dm_addr, ireg_value, ext_low_addr, stk_addr, offset_addr;
    logic [15:0] ireg_byte_addr, wide_operand;
    logic [16:0] abs_target, pc_addr;
    logic [17:0] rom_addr, lookup_addr;
    logic [23:0] muldiv_result, ext_addr;
    int fails, samples_checked, cycles;
    cpsq_core i_cpsq_core (.*, .stack_ptr_next());
    cpsq_ram_model u_ram (.*);
    // ==========================================================
    // Clock and hang guard
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            stop_test();
        end
    end
    // ==========================================================
    // Tasks
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stp(input logic [3:0] op, input logic [16:0] a);
        step_op = op;
        abs_target = a;
        step_valid = 1'b1;
        @(negedge clock);
        step_valid = 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        dm_addr = a;
        dm_wdata = d;
        dm_we = 1'b1;
        @(negedge clock);
        dm_we = 1'b0;
    endtask
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {step_valid, cond_taken, dm_we, flag_ram8_in, acc_core_we, muldiv_we} = '0;
        {table_lookup_instr, lookup_bank, ext_load_instr, ext_store_instr} = '0;
        {step_op, int_source, instr_bytes, abs_target, rel12, rel8, ireg_index} = '0;
        {dm_addr, dm_wdata, acc_core_wdata, stack_ptr, ireg_value, ext_low_addr} = '0;
        {muldiv_result, ireg_hi, ireg_lo} = '0;
        rst_n = 1'b0;
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        chk({bank_select_flag, pc_addr}, 18'h0);
        chk({accumulator_reg, second_work_reg, third_work_reg}, 24'h0);
        // Register access, unmapped SFR reads zero
        wr(16'hFE00, 8'hFF);
        wr(16'hFE01, 8'h5A);
        wr(16'hFE02, 8'h80);
        chk(dm_rdata, 8'h80);
        dm_addr = 16'hFE03;
        #1 chk(dm_rdata, 8'h00);
        dm_addr = 16'hFDFF;
        #1 chk(dm_is_ram, 1'b1);
        {dm_we, flag_ram8_in, dm_wdata} = {2'b11, 8'h3C};
        #1 chk({dm_ram_we, dm_ram_wdata}, 10'h33C);
        {dm_we, flag_ram8_in} = 2'b00;
        chk(wide_operand, 16'h5AFF);
        ext_load_instr = 1'b1;
        ext_low_addr = 16'h1234;
        #1 chk(ext_addr, 24'h5A1234);
        ext_load_instr = 1'b0;
        #1 chk(ext_addr, 24'h0);
        ireg_value = 16'h1000;
        ireg_index = 6'h3F;
        #1 chk(offset_addr, 16'h0F80);
        chk(ireg_byte_addr, 16'h007E);
        {table_lookup_instr, lookup_bank, ireg_hi, ireg_lo} = {2'b11, 9'h1AB, 8'hCD};
        #1 chk(lookup_addr, 18'h3ABCD);
        // Program flow with boundary offsets, back on the falling edge
        @(negedge clock);
        instr_bytes = 3'h3;
        stp(`CPSQ_OP_SEQ, 17'h0);
        chk(pc_addr, 17'h3);
        rel12 = 12'h800;
        stp(`CPSQ_OP_BR, 17'h0);
        chk(pc_addr, 17'h1F805);
        rel8 = 8'h80;
        cond_taken = 1'b1;
        stp(`CPSQ_OP_BCOND, 17'h0);
        chk(pc_addr, 17'h1F788);
        cond_taken = 1'b0;
        stp(`CPSQ_OP_BCOND, 17'h0);
        chk(pc_addr, 17'h1F78B);
        instr_bytes = 3'h1;
        stack_ptr = 16'h0100;
        stp(`CPSQ_OP_ACC_RELATIVE_CALL_INSTR, 17'h0);
        chk(pc_addr, 17'h1F88B);
        @(negedge clock);
        stack_ptr = 16'h0102;
        stp(`CPSQ_OP_RET, 17'h0);
        chk({bank_select_flag, pc_addr}, 18'h1F78C);
        // Bank change through a return; a jump and a call keep it
        u_ram.mem[16'h0201] = 9'h1AB;
        u_ram.mem[16'h0202] = 9'h012;
        stack_ptr = 16'h0202;
        stp(`CPSQ_OP_RET, 17'h0);
        chk({bank_select_flag, pc_addr}, 18'h212AB);
        stp(`CPSQ_OP_JUMP, 17'h0FF00);
        chk(rom_addr, 18'h2FF00);
        chk(opt_area_hit, 1'b0);
        instr_bytes = 3'h3;
        stack_ptr = 16'h0300;
        stp(`CPSQ_OP_CALL, 17'h0ABCD);
        chk({bank_select_flag, pc_addr}, 18'h2ABCD);
        @(negedge clock);
        stack_ptr = 16'h0302;
        stp(`CPSQ_OP_RET, 17'h0);
        chk({bank_select_flag, pc_addr}, 18'h2FF03);
        // Relative call at the top offset, then back
        rel12 = 12'h7FF;
        stack_ptr = 16'h0300;
        stp(`CPSQ_OP_RELATIVE_CALL_INSTR, 17'h0);
        chk({bank_select_flag, pc_addr}, 18'h30704);
        chk(stk_second, 1'b1);
        @(negedge clock);
        stack_ptr = 16'h0302;
        stp(`CPSQ_OP_RET, 17'h0);
        chk({bank_select_flag, pc_addr}, 18'h2FF06);
        // Every vector and a clamped source
        for (int n = 0; n < 11; n++) begin
            int_source = n[3:0];
            stp(`CPSQ_OP_INT, 17'h0);
            chk({bank_select_flag, pc_addr}, 18'h3 + 18'h8 * 18'((n > 9) ? 9 : n));
            @(negedge clock);
        end
        stp(`CPSQ_OP_JUMP, 17'h0FF00);
        chk(opt_area_hit, 1'b1);
        // Result loads; core load beats a bus write
        {muldiv_we, muldiv_result} = {1'b1, 24'h332211};
        @(negedge clock);
        muldiv_we = 1'b0;
        chk({third_work_reg, second_work_reg, accumulator_reg}, 24'h332211);
        {acc_core_we, acc_core_wdata} = {1'b1, 8'h77};
        wr(16'hFE00, 8'h11);
        acc_core_we = 1'b0;
        chk(accumulator_reg, 8'h77);
        // Reset again in mid-run
        rst_n = 1'b0;
        @(negedge clock);
        rst_n = 1'b1;
        chk({bank_select_flag, pc_addr}, 18'h0);
        chk({accumulator_reg, second_work_reg, third_work_reg}, 24'h0);
        repeat (2) @(negedge clock);
        chk({bank_select_flag, pc_addr}, 18'h0);
        stop_test();
    end
endmodule
bind cpsq_core cpsq_properties i_cpsq_properties (.clock, .rst_n, .step_valid, .step_op,
    .instr_bytes, .abs_target, .rel12, .int_source, .stack_ptr, .ret_hi_word, .ret_lo_word,
    .pc_addr, .bank_select_flag, .stk_we, .stk_addr, .stk_wdata, .wide_operand,
    .accumulator_reg, .second_work_reg, .third_work_reg);
`default_nettype wire
